// ### core/cmt_core_timing.sv
// Purpose: Mode, privilege, debug state and per-instruction cycle timing of the core
// Assumes: One instruction issued at a time; operands of a divide come with its issue
// Notes: Memory wait stretches every base and refill cycle but not the cycles of a divide
//
// Overview of operation
// - Reset and exception return put the core in thread mode.
// - Taking an exception enters handler mode, always privileged.
// - Thread mode runs privileged or unprivileged; the level is held state.
// - Unprivileged code is refused some resources; privileged code gets all.
// - Normal state runs 16 and 32 bit halfword-aligned instructions.
// - A separate debug halted state exists beside normal execution.
// - Cycle figures assume zero wait states; memory waits lengthen them.
// - Pipeline refill costs 1 to 3 cycles by target alignment, width, speculation.
// - Data barriers take one base cycle plus zero or more extra cycles.
// - Instruction barrier adds at least a pipeline refill to its base cycle.
// - Register list transfers count every listed register, program counter included.
// - Wait hints take one cycle plus cycles waiting for their event.
// - Second operand is register, shifted register, register-shifted register or immediate.
// - Register add, subtract, move, compare, logic: 1 cycle; program counter write refills.
// - Shifts and rotates take 1 cycle with immediate or register amount.
// - Signed and unsigned saturate take 1 cycle.
// - Long multiplies, signed and unsigned, take 1 cycle.
// - Long multiply-accumulates take 1 cycle; word multiply-accumulate and subtract take 2.
// - Division terminates early and takes 2 to 10 cycles.
`include "cmt_map.svh"
module cmt_core_timing (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic issue_valid_i,
  input wire cmt_pkg::cmt_op_e issue_op_i,
  input wire cmt_pkg::cmt_operand_form_e issue_form_i,
  input wire logic issue_addr_lsb_i,
  input wire logic issue_dest_pc_i,
  input wire logic [4:0] issue_reg_count_i,
  input wire logic issue_signed_i,
  input wire logic [31:0] issue_opa_i,
  input wire logic [31:0] issue_opb_i,
  input wire logic tgt_wide_i,
  input wire logic tgt_word_aligned_i,
  input wire logic tgt_speculated_i,
  input wire logic mem_wait_i,
  input wire logic mem_idle_i,
  input wire logic event_pin_i,
  input wire logic irq_pin_i,
  input wire logic exc_take_i,
  input wire logic exc_return_i,
  input wire logic thread_unpriv_we_i,
  input wire logic thread_unpriv_i,
  input wire logic halt_req_i,
  input wire logic resume_i,
  input wire logic access_req_i,
  input wire logic access_needs_priv_i,
  output logic issue_ready_o,
  output logic busy_o,
  output logic retire_o,
  output logic [`CMT_CYC_CNT_W-1:0] retire_cycles_o,
  output logic [31:0] div_result_o,
  output logic misalign_o,
  output logic illegal_o,
  output logic handler_mode_o,
  output logic privileged_o,
  output logic debug_halted_o,
  output logic access_grant_o,
  output logic access_fault_o
);
  cmt_div_if dv_if();

  cmt_divider u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .dv(dv_if.div)
  );

  logic ev_meta_r, ev_sync_r, irq_meta_r, irq_sync_r;
  cmt_pkg::cmt_state_e state_r, state_nxt;
  cmt_pkg::cmt_op_e op_r, op_nxt;
  logic [`CMT_REM_W-1:0] rem_r, rem_nxt, refill_r, refill_nxt;
  logic [`CMT_CYC_CNT_W-1:0] cyc_r, cyc_nxt, cyc_out_r, cyc_out_nxt;
  logic ready_r, ready_nxt, busy_r, busy_nxt, retire_r, retire_nxt;
  logic [31:0] div_res_r, div_res_nxt;
  logic misalign_r, misalign_nxt, illegal_r, illegal_nxt;
  logic halted_r, halted_nxt, evt_flag_r, evt_flag_nxt;
  cmt_pkg::cmt_mode_e mode_r, mode_nxt;
  logic unpriv_r, unpriv_nxt, priv_r, priv_nxt;
  logic grant_r, grant_nxt, fault_r, fault_nxt;
  logic offered, form_ok, accept, wait_more, finish, evt_consume;
  logic [`CMT_REM_W-1:0] base_cyc, refill_cost;
  logic [`CMT_CYC_CNT_W-1:0] cyc_inc;

  // Outside events are synchronised before any logic looks at them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ev_meta_r <= 1'b0;
      ev_sync_r <= 1'b0;
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
    end else begin
      ev_meta_r <= event_pin_i;
      ev_sync_r <= ev_meta_r;
      irq_meta_r <= irq_pin_i;
      irq_sync_r <= irq_meta_r;
    end
  end

  // Refill cost from the target's placement and whether its address came early
  always_comb begin
    if (tgt_speculated_i) begin
      refill_cost = `CMT_REFILL_FAST;
    end else if (!tgt_wide_i || tgt_word_aligned_i) begin
      refill_cost = `CMT_REFILL_MID;
    end else begin
      refill_cost = `CMT_REFILL_SLOW;
    end
  end

  always_comb begin
    unique case (issue_op_i)
      cmt_pkg::OP_ALU: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_SHIFT: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_SATURATE: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_MUL: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_LONG_MUL: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_LONG_MAC: base_cyc = `CMT_CYC_SINGLE;
      cmt_pkg::OP_WORD_MAC: base_cyc = `CMT_CYC_WORD_MAC;
      cmt_pkg::OP_REG_LIST: base_cyc = `CMT_CYC_SINGLE + {1'b0, issue_reg_count_i};
      default: base_cyc = `CMT_CYC_SINGLE;
    endcase
  end

  // Data-processing ops take any operand form; the rest only a plain register
  assign form_ok = (issue_op_i == cmt_pkg::OP_ALU) || (issue_op_i == cmt_pkg::OP_SHIFT) ||
                   (issue_op_i == cmt_pkg::OP_SATURATE) ||
                   (issue_form_i == cmt_pkg::FORM_REG);
  assign offered = issue_valid_i && ready_r && (state_r == cmt_pkg::ST_IDLE);
  assign accept = offered && !issue_addr_lsb_i && form_ok;

  assign dv_if.start = accept && (issue_op_i == cmt_pkg::OP_DIVIDE);
  assign dv_if.is_signed = issue_signed_i;
  assign dv_if.dividend = issue_opa_i;
  assign dv_if.divisor = issue_opb_i;

  // Extra cycles a barrier or hint still needs after its base cycle
  always_comb begin
    unique case (op_r)
      cmt_pkg::OP_DATA_SYNC_BARRIER: wait_more = !mem_idle_i;
      cmt_pkg::OP_DATA_MEMORY_BARRIER: wait_more = !mem_idle_i;
      cmt_pkg::OP_WAIT_EVENT_HINT: wait_more = !(evt_flag_r || ev_sync_r || irq_sync_r);
      cmt_pkg::OP_WAIT_INTERRUPT_HINT: wait_more = !irq_sync_r;
      default: wait_more = 1'b0;
    endcase
  end

  assign cyc_inc = (cyc_r == `CMT_CYC_CNT_MAX) ? cyc_r : cyc_r + 8'h01;

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    rem_nxt = rem_r;
    refill_nxt = refill_r;
    cyc_nxt = cyc_inc;
    cyc_out_nxt = cyc_out_r;
    div_res_nxt = div_res_r;
    misalign_nxt = offered && issue_addr_lsb_i;
    illegal_nxt = offered && !issue_addr_lsb_i && !form_ok;
    finish = 1'b0;
    unique case (state_r)
      cmt_pkg::ST_IDLE: begin
        cyc_nxt = 8'h00;
        if (accept) begin
          op_nxt = issue_op_i;
          rem_nxt = base_cyc;
          refill_nxt = 6'h00;
          if ((issue_dest_pc_i && issue_op_i == cmt_pkg::OP_ALU) ||
              issue_op_i == cmt_pkg::OP_INSTRUCTION_SYNC_BARRIER) begin
            refill_nxt = refill_cost;
          end
          state_nxt = (issue_op_i == cmt_pkg::OP_DIVIDE) ? cmt_pkg::ST_DIV : cmt_pkg::ST_EXEC;
        end else if (halt_req_i) begin
          state_nxt = cmt_pkg::ST_HALT;
        end
      end
      cmt_pkg::ST_EXEC: begin
        if (!mem_wait_i) begin
          if (rem_r == 6'h01) begin
            if (refill_r != 6'h00) begin
              state_nxt = cmt_pkg::ST_REFILL;
              rem_nxt = refill_r;
              refill_nxt = 6'h00;
            end else if (wait_more) begin
              state_nxt = cmt_pkg::ST_WAIT;
            end else begin
              finish = 1'b1;
            end
          end else begin
            rem_nxt = rem_r - 6'h01;
          end
        end
      end
      cmt_pkg::ST_REFILL: begin
        if (!mem_wait_i) begin
          if (rem_r == 6'h01) begin
            finish = 1'b1;
          end else begin
            rem_nxt = rem_r - 6'h01;
          end
        end
      end
      cmt_pkg::ST_WAIT: begin
        finish = !wait_more;
      end
      cmt_pkg::ST_DIV: begin
        if (dv_if.done) begin
          div_res_nxt = dv_if.quotient;
          finish = 1'b1;
        end
      end
      cmt_pkg::ST_HALT: begin
        cyc_nxt = 8'h00;
        if (resume_i) begin
          state_nxt = cmt_pkg::ST_IDLE;
        end
      end
      default: state_nxt = cmt_pkg::ST_IDLE;
    endcase
    if (finish) begin
      state_nxt = cmt_pkg::ST_IDLE;
      cyc_out_nxt = cyc_inc;
    end
    retire_nxt = finish;
    evt_consume = finish && (op_r == cmt_pkg::OP_WAIT_EVENT_HINT);
    // A fresh event in the consuming cycle survives
    evt_flag_nxt = (evt_flag_r && !evt_consume) || ev_sync_r;
    // Nothing new issues until the current operation retires
    ready_nxt = (state_nxt == cmt_pkg::ST_IDLE) && !halt_req_i;
    busy_nxt = (state_nxt != cmt_pkg::ST_IDLE) && (state_nxt != cmt_pkg::ST_HALT);
    halted_nxt = (state_nxt == cmt_pkg::ST_HALT);
  end

  // Mode and privilege; an exception taken wins over a return in the same cycle
  always_comb begin
    mode_nxt = mode_r;
    unpriv_nxt = unpriv_r;
    if (exc_take_i) begin
      mode_nxt = cmt_pkg::MODE_HANDLER;
    end else if (exc_return_i) begin
      mode_nxt = cmt_pkg::MODE_THREAD;
    end
    // Privileged code may drop its level; unprivileged code can never raise it
    if (thread_unpriv_we_i && (priv_r || thread_unpriv_i)) begin
      unpriv_nxt = thread_unpriv_i;
    end
    priv_nxt = (mode_nxt == cmt_pkg::MODE_HANDLER) || !unpriv_nxt;
    grant_nxt = access_req_i && (priv_r || !access_needs_priv_i);
    fault_nxt = access_req_i && !priv_r && access_needs_priv_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= cmt_pkg::ST_IDLE;
      op_r <= cmt_pkg::OP_ALU;
      rem_r <= 6'h00;
      refill_r <= 6'h00;
      cyc_r <= 8'h00;
      cyc_out_r <= 8'h00;
      ready_r <= 1'b0;
      busy_r <= 1'b0;
      retire_r <= 1'b0;
      div_res_r <= 32'h0;
      misalign_r <= 1'b0;
      illegal_r <= 1'b0;
      halted_r <= 1'b0;
      evt_flag_r <= 1'b0;
      mode_r <= cmt_pkg::MODE_THREAD;
      unpriv_r <= 1'b0;
      priv_r <= 1'b1;
      grant_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      rem_r <= rem_nxt;
      refill_r <= refill_nxt;
      cyc_r <= cyc_nxt;
      cyc_out_r <= cyc_out_nxt;
      ready_r <= ready_nxt;
      busy_r <= busy_nxt;
      retire_r <= retire_nxt;
      div_res_r <= div_res_nxt;
      misalign_r <= misalign_nxt;
      illegal_r <= illegal_nxt;
      halted_r <= halted_nxt;
      evt_flag_r <= evt_flag_nxt;
      mode_r <= mode_nxt;
      unpriv_r <= unpriv_nxt;
      priv_r <= priv_nxt;
      grant_r <= grant_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign issue_ready_o = ready_r;
  assign busy_o = busy_r;
  assign retire_o = retire_r;
  assign retire_cycles_o = cyc_out_r;
  assign div_result_o = div_res_r;
  assign misalign_o = misalign_r;
  assign illegal_o = illegal_r;
  assign handler_mode_o = (mode_r == cmt_pkg::MODE_HANDLER);
  assign privileged_o = priv_r;
  assign debug_halted_o = halted_r;
  assign access_grant_o = grant_r;
  assign access_fault_o = fault_r;
endmodule

// ### include/cmt_map.svh
// Purpose: Widths and cycle figures of the mode and cycle timing block
// Assumes: Zero wait state memory for every nominal figure
// Notes: Counts are in core clock cycles at 40 MHz
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH
`define CMT_XLEN 32
`define CMT_REM_W 6
`define CMT_CYC_CNT_W 8
`define CMT_CYC_CNT_MAX 8'hff
`define CMT_CYC_SINGLE 6'h01
`define CMT_CYC_WORD_MAC 6'h02
`define CMT_REFILL_FAST 6'h01
`define CMT_REFILL_MID 6'h02
`define CMT_REFILL_SLOW 6'h03
`define CMT_DIV_BITS_PER_CYC 4
`define CMT_DIV_ITER_W 4
`define CMT_DIV_FULL_ITER 4'h8
`endif

// ### include/cmt_pkg.sv
// Purpose: Types shared by the mode and cycle timing block
// Assumes: Nothing beyond the map header
// Notes: State codes follow a Gray path idle-exec-refill-wait-div
package cmt_pkg;
  typedef enum logic [3:0] {
    OP_ALU = 4'h0,
    OP_SHIFT = 4'h1,
    OP_SATURATE = 4'h2,
    OP_MUL = 4'h3,
    OP_LONG_MUL = 4'h4,
    OP_LONG_MAC = 4'h5,
    OP_WORD_MAC = 4'h6,
    OP_DIVIDE = 4'h7,
    OP_REG_LIST = 4'h8,
    OP_DATA_SYNC_BARRIER = 4'h9,
    OP_DATA_MEMORY_BARRIER = 4'ha,
    OP_INSTRUCTION_SYNC_BARRIER = 4'hb,
    OP_WAIT_EVENT_HINT = 4'hc,
    OP_WAIT_INTERRUPT_HINT = 4'hd
  } cmt_op_e;

  typedef enum logic [1:0] {
    FORM_REG = 2'h0,
    FORM_REG_SHIFT_IMM = 2'h1,
    FORM_REG_SHIFT_REG = 2'h2,
    FORM_IMM = 2'h3
  } cmt_operand_form_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EXEC = 3'h1,
    ST_REFILL = 3'h3,
    ST_WAIT = 3'h2,
    ST_DIV = 3'h6,
    ST_HALT = 3'h4
  } cmt_state_e;

  typedef enum logic {
    MODE_THREAD = 1'b0,
    MODE_HANDLER = 1'b1
  } cmt_mode_e;

  typedef enum logic [1:0] {
    DV_IDLE = 2'h0,
    DV_PREP = 2'h1,
    DV_RUN = 2'h3
  } cmt_div_state_e;
endpackage

// ### include/cmt_div_if.sv
// Purpose: Carrier between the timing control and the divider
// Assumes: Start is a one-cycle pulse on the core clock
// Notes: Quotient is valid only while done is high
interface cmt_div_if;
  logic start;
  logic is_signed;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic [31:0] quotient;
  logic done;
  modport core(output start, output is_signed, output dividend, output divisor,
               input quotient, input done);
  modport div(input start, input is_signed, input dividend, input divisor,
              output quotient, output done);
endinterface

// ### core/cmt_divider.sv
// Purpose: Early-terminating divider, four quotient bits per cycle
// Assumes: A new start only after done
// Notes: Leading zero nibbles of the dividend are skipped; divide by zero gives 0
`include "cmt_map.svh"
module cmt_divider (
  input wire logic clk_i,
  input wire logic reset_i,
  cmt_div_if.div dv
);
  cmt_pkg::cmt_div_state_e st_r, st_nxt;
  logic [31:0] num_r, num_nxt, den_r, den_nxt, quo_r, quo_nxt;
  logic [32:0] rem_r, rem_nxt;
  logic [`CMT_DIV_ITER_W-1:0] iter_r, iter_nxt;
  logic neg_r, neg_nxt, zero_r, zero_nxt;
  logic [5:0] lead;

  function automatic logic [5:0] clz32(input logic [31:0] v);
    logic [5:0] n;
    logic seen;
    n = 6'h20;
    seen = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!seen && v[i]) begin
        n = 6'(31 - i);
        seen = 1'b1;
      end
    end
    return n;
  endfunction

  always_comb begin
    st_nxt = st_r;
    num_nxt = num_r;
    den_nxt = den_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    iter_nxt = iter_r;
    neg_nxt = neg_r;
    zero_nxt = zero_r;
    lead = clz32(num_r);
    dv.done = 1'b0;
    dv.quotient = zero_r ? 32'h0 : (neg_r ? 32'(-quo_r) : quo_r);
    case (st_r)
      cmt_pkg::DV_IDLE: begin
        if (dv.start) begin
          num_nxt = (dv.is_signed && dv.dividend[31]) ? 32'(-dv.dividend) : dv.dividend;
          den_nxt = (dv.is_signed && dv.divisor[31]) ? 32'(-dv.divisor) : dv.divisor;
          neg_nxt = dv.is_signed && (dv.dividend[31] ^ dv.divisor[31]);
          zero_nxt = (dv.divisor == 32'h0);
          rem_nxt = 33'h0;
          quo_nxt = 32'h0;
          st_nxt = cmt_pkg::DV_PREP;
        end
      end
      cmt_pkg::DV_PREP: begin
        // Skip whole zero nibbles so every remaining step consumes real bits
        num_nxt = num_r << {lead[5:2], 2'b00};
        iter_nxt = zero_r ? 4'h0 : 4'(`CMT_DIV_FULL_ITER - {1'b0, lead[5:2]});
        st_nxt = cmt_pkg::DV_RUN;
      end
      cmt_pkg::DV_RUN: begin
        if (iter_r == 4'h0) begin
          dv.done = 1'b1;
          st_nxt = cmt_pkg::DV_IDLE;
        end else begin
          for (int k = 0; k < `CMT_DIV_BITS_PER_CYC; k++) begin
            rem_nxt = {rem_nxt[31:0], num_nxt[31]};
            num_nxt = {num_nxt[30:0], 1'b0};
            if (rem_nxt >= {1'b0, den_r}) begin
              rem_nxt = rem_nxt - {1'b0, den_r};
              quo_nxt = {quo_nxt[30:0], 1'b1};
            end else begin
              quo_nxt = {quo_nxt[30:0], 1'b0};
            end
          end
          iter_nxt = iter_r - 4'h1;
        end
      end
      default: st_nxt = cmt_pkg::DV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= cmt_pkg::DV_IDLE;
      num_r <= 32'h0;
      den_r <= 32'h0;
      quo_r <= 32'h0;
      rem_r <= 33'h0;
      iter_r <= 4'h0;
      neg_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      iter_r <= iter_nxt;
      neg_r <= neg_nxt;
      zero_r <= zero_nxt;
    end
  end
endmodule

// ### testbench/cmt_core_timing_asserts.sv
// Purpose: Port checker of mode, access and cycle timing
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to every instance of the timing block
`include "cmt_map.svh"
module cmt_core_timing_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic issue_valid_i,
  input wire cmt_pkg::cmt_op_e issue_op_i,
  input wire cmt_pkg::cmt_operand_form_e issue_form_i,
  input wire logic issue_addr_lsb_i,
  input wire logic issue_dest_pc_i,
  input wire logic mem_wait_i,
  input wire logic exc_take_i,
  input wire logic exc_return_i,
  input wire logic access_req_i,
  input wire logic access_needs_priv_i,
  input wire logic issue_ready_o,
  input wire logic busy_o,
  input wire logic retire_o,
  input wire logic [`CMT_CYC_CNT_W-1:0] retire_cycles_o,
  input wire logic misalign_o,
  input wire logic handler_mode_o,
  input wire logic privileged_o,
  input wire logic debug_halted_o,
  input wire logic access_grant_o,
  input wire logic access_fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic acc;
  cmt_pkg::cmt_op_e op_r, op_nxt;
  assign acc = issue_valid_i && issue_ready_o && !issue_addr_lsb_i &&
    (issue_form_i == cmt_pkg::FORM_REG ||
    issue_op_i inside {cmt_pkg::OP_ALU, cmt_pkg::OP_SHIFT, cmt_pkg::OP_SATURATE});
  always_comb begin
    op_nxt = acc ? issue_op_i : op_r;
  end
  always_ff @(posedge clk_i) begin
    op_r <= op_nxt;
  end
  sequence s_one_take;
    acc && !issue_dest_pc_i && issue_op_i inside {cmt_pkg::OP_ALU, cmt_pkg::OP_SHIFT,
      cmt_pkg::OP_SATURATE, cmt_pkg::OP_MUL, cmt_pkg::OP_LONG_MUL, cmt_pkg::OP_LONG_MAC};
  endsequence
  sequence s_mac_take;
    acc && issue_op_i == cmt_pkg::OP_WORD_MAC;
  endsequence
  property p_reset_mode; $fell(reset_i) |-> !handler_mode_o && privileged_o; endproperty
  property p_exc_take; exc_take_i |=> handler_mode_o && privileged_o; endproperty
  property p_exc_ret; exc_return_i && !exc_take_i |=> !handler_mode_o; endproperty
  property p_hm_priv; handler_mode_o |-> privileged_o; endproperty
  property p_access;
    access_req_i |=> access_grant_o == ($past(privileged_o) || !$past(access_needs_priv_i))
      && access_fault_o == !access_grant_o;
  endproperty
  property p_misalign;
    issue_valid_i && issue_ready_o && issue_addr_lsb_i |=> misalign_o && !busy_o;
  endproperty
  property p_one_cyc;
    s_one_take ##1 !mem_wait_i |-> ##1 retire_o && retire_cycles_o == 8'h01;
  endproperty
  property p_wmac;
    s_mac_take ##1 !mem_wait_i [*2] |-> ##1 retire_o && retire_cycles_o == 8'h02;
  endproperty
  property p_div_range;
    retire_o && op_r == cmt_pkg::OP_DIVIDE |-> retire_cycles_o inside {[8'h02:8'h0c]};
  endproperty
  property p_stall; busy_o || debug_halted_o |-> !issue_ready_o; endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode after reset");
  a_exc_take: assert property (p_exc_take) else $error("handler entry");
  a_exc_ret: assert property (p_exc_ret) else $error("thread on return");
  a_hm_priv: assert property (p_hm_priv) else $error("handler unprivileged");
  a_access: assert property (p_access) else $error("access answer");
  a_misalign: assert property (p_misalign) else $error("misaligned taken");
  a_one_cyc: assert property (p_one_cyc) else $error("single cycle op");
  a_wmac: assert property (p_wmac) else $error("word mac timing");
  a_div_range: assert property (p_div_range) else $error("divide cycles");
  a_stall: assert property (p_stall) else $error("issue while busy");
endmodule

bind cmt_core_timing cmt_core_timing_asserts u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i),
  .issue_op_i(issue_op_i), .issue_form_i(issue_form_i), .issue_addr_lsb_i(issue_addr_lsb_i),
  .issue_dest_pc_i(issue_dest_pc_i), .mem_wait_i(mem_wait_i), .exc_take_i(exc_take_i),
  .exc_return_i(exc_return_i), .access_req_i(access_req_i),
  .access_needs_priv_i(access_needs_priv_i), .issue_ready_o(issue_ready_o),
  .busy_o(busy_o), .retire_o(retire_o), .retire_cycles_o(retire_cycles_o),
  .misalign_o(misalign_o), .handler_mode_o(handler_mode_o), .privileged_o(privileged_o),
  .debug_halted_o(debug_halted_o), .access_grant_o(access_grant_o),
  .access_fault_o(access_fault_o));

// ### testbench/cmt_mem_model.sv
// Purpose: Memory system beside the core, slow or prompt on command
// Assumes: take_i marks the edge an instruction is accepted
// Notes: Wait states and drain time are counted from that edge
module cmt_mem_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic take_i,
  input wire logic [3:0] waits_i,
  input wire logic [3:0] drain_i,
  output logic mem_wait_o,
  output logic mem_idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r, wait_nxt, drain_r, drain_nxt;
  always_comb begin
    wait_nxt = take_i ? waits_i : wait_r - {3'h0, wait_r != 4'h0};
    drain_nxt = take_i ? drain_i : drain_r - {3'h0, drain_r != 4'h0};
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_r <= 4'h0;
      drain_r <= 4'h0;
    end else begin
      wait_r <= wait_nxt;
      drain_r <= drain_nxt;
    end
  end
  assign mem_wait_o = wait_r != 4'h0;
  assign mem_idle_o = drain_r == 4'h0;
endmodule

// ### testbench/cmt_core_timing_test.sv
// Purpose: Self-checking bench of the mode and cycle timing block
// Assumes: Zero wait states unless the memory model is told otherwise
// Notes: Each scenario task drives the block and judges its answers
`include "cmt_map.svh"
module cmt_core_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, vld, lsb, dpc, sgn, tw, ta, ts, ev, irq, xt, xr, uwe, uv;
  logic hr, rs, ar, anp, mw, mi, rdy, busy, ret, mis, ill, hm, pv, dh, ag, af;
  cmt_pkg::cmt_op_e op = cmt_pkg::OP_ALU;
  cmt_pkg::cmt_operand_form_e fm = cmt_pkg::FORM_REG;
  logic [4:0] nreg;
  logic [31:0] opa, opb, dres;
  logic [3:0] waits, drain;
  logic [7:0] cyc;
  int num_errors, n_checks, ticks;
  cmt_core_timing DUT (.clk_i(clk_i), .reset_i(reset_i), .issue_valid_i(vld),
    .issue_op_i(op), .issue_form_i(fm), .issue_addr_lsb_i(lsb), .issue_dest_pc_i(dpc),
    .issue_reg_count_i(nreg), .issue_signed_i(sgn), .issue_opa_i(opa), .issue_opb_i(opb),
    .tgt_wide_i(tw), .tgt_word_aligned_i(ta), .tgt_speculated_i(ts), .mem_wait_i(mw),
    .mem_idle_i(mi), .event_pin_i(ev), .irq_pin_i(irq), .exc_take_i(xt),
    .exc_return_i(xr), .thread_unpriv_we_i(uwe), .thread_unpriv_i(uv), .halt_req_i(hr),
    .resume_i(rs), .access_req_i(ar), .access_needs_priv_i(anp), .issue_ready_o(rdy),
    .busy_o(busy), .retire_o(ret), .retire_cycles_o(cyc), .div_result_o(dres),
    .misalign_o(mis), .illegal_o(ill), .handler_mode_o(hm), .privileged_o(pv),
    .debug_halted_o(dh), .access_grant_o(ag), .access_fault_o(af));
  cmt_mem_model u_mem (.clk_i(clk_i), .reset_i(reset_i), .take_i(vld && rdy),
    .waits_i(waits), .drain_i(drain), .mem_wait_o(mw), .mem_idle_o(mi));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // Offers one instruction, waits for retirement; exp of zero skips the count check
  task automatic issue(input cmt_pkg::cmt_op_e o, input logic [7:0] exp);
    int k;
    @(posedge clk_i);
    op <= o;
    vld <= 1'b1;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    @(posedge clk_i);
    vld <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (ret !== 1'b1 && k < 60);
    chk(ret, 1'b1);
    if (exp != 8'h00) begin
      chk(cyc, exp);
    end
  endtask
  task automatic t_ops();
    for (int f = 0; f < 4; f++) begin
      fm <= cmt_pkg::cmt_operand_form_e'(f);
      issue(cmt_pkg::OP_ALU, 8'h01);
    end
    fm <= cmt_pkg::FORM_REG;
    issue(cmt_pkg::OP_SHIFT, 8'h01);
    issue(cmt_pkg::OP_SATURATE, 8'h01);
    issue(cmt_pkg::OP_LONG_MUL, 8'h01);
    issue(cmt_pkg::OP_LONG_MAC, 8'h01);
    issue(cmt_pkg::OP_WORD_MAC, 8'h02);
    nreg <= 5'h10;
    issue(cmt_pkg::OP_REG_LIST, 8'h11);
    issue(cmt_pkg::OP_DATA_SYNC_BARRIER, 8'h01);
    issue(cmt_pkg::OP_DATA_MEMORY_BARRIER, 8'h01);
    waits <= 4'h2;
    issue(cmt_pkg::OP_MUL, 8'h03);
    issue(cmt_pkg::OP_WORD_MAC, 8'h04);
    waits <= 4'h0;
    drain <= 4'h3;
    issue(cmt_pkg::OP_DATA_SYNC_BARRIER, 8'h00);
    chk(cyc >= 8'h02 && cyc <= 8'h04, 1'b1);
    drain <= 4'h0;
  endtask
  task automatic t_refill();
    logic [2:0] tg [4] = '{3'b100, 3'b000, 3'b011, 3'b010};
    logic [7:0] pf [4] = '{8'h01, 8'h02, 8'h02, 8'h03};
    for (int i = 0; i < 4; i++) begin
      {ts, tw, ta} <= tg[i];
      dpc <= 1'b1;
      issue(cmt_pkg::OP_ALU, 8'h01 + pf[i]);
      issue(cmt_pkg::OP_INSTRUCTION_SYNC_BARRIER, 8'h01 + pf[i]);
    end
    dpc <= 1'b0;
  endtask
  task automatic div(input logic [31:0] a, b, input logic s, logic [7:0] t, logic [31:0] q);
    opa <= a;
    opb <= b;
    sgn <= s;
    issue(cmt_pkg::OP_DIVIDE, t);
    chk(cyc >= 8'h02 && cyc <= 8'h0c, 1'b1);
    chk(dres, q);
  endtask
  task automatic t_hint(input cmt_pkg::cmt_op_e o);
    fork
      issue(o, 8'h00);
      begin
        repeat (10) @(posedge clk_i);
        ev <= o == cmt_pkg::OP_WAIT_EVENT_HINT;
        irq <= o == cmt_pkg::OP_WAIT_INTERRUPT_HINT;
        @(posedge clk_i);
        ev <= 1'b0;
        irq <= 1'b0;
      end
    join
    chk(cyc >= 8'h08 && cyc <= 8'h0e, 1'b1);
  endtask
  task automatic mode(input logic [3:0] c, input logic eh, ep);
    @(posedge clk_i);
    {xt, xr, uwe, uv} <= c;
    @(posedge clk_i);
    {xt, xr, uwe, uv} <= 4'h0;
    @(negedge clk_i);
    chk({hm, pv}, {eh, ep});
  endtask
  task automatic acc(input logic np, eg);
    @(posedge clk_i);
    ar <= 1'b1;
    anp <= np;
    @(posedge clk_i);
    ar <= 1'b0;
    @(negedge clk_i);
    chk({ag, af}, {eg, ~eg});
  endtask
  task automatic t_mode();
    mode(4'h3, 1'b0, 1'b0);
    acc(1'b1, 1'b0);
    acc(1'b0, 1'b1);
    mode(4'h2, 1'b0, 1'b0);
    mode(4'h8, 1'b1, 1'b1);
    acc(1'b1, 1'b1);
    mode(4'h2, 1'b1, 1'b1);
    mode(4'h4, 1'b0, 1'b1);
    mode(4'hc, 1'b1, 1'b1);
    mode(4'h4, 1'b0, 1'b1);
  endtask
  task automatic t_debug();
    @(posedge clk_i);
    hr <= 1'b1;
    repeat (3) @(posedge clk_i);
    hr <= 1'b0;
    @(negedge clk_i);
    chk({dh, rdy}, 2'b10);
    @(posedge clk_i);
    rs <= 1'b1;
    @(posedge clk_i);
    rs <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({dh, rdy}, 2'b01);
  endtask
  task automatic refuse(input logic l, cmt_pkg::cmt_operand_form_e f, cmt_pkg::cmt_op_e o);
    @(posedge clk_i);
    {lsb, vld} <= {l, 1'b1};
    fm <= f;
    op <= o;
    @(posedge clk_i);
    {lsb, vld} <= 2'b00;
    @(negedge clk_i);
    chk({mis, ill, busy, rdy}, {l, ~l, 2'b01});
  endtask
  initial begin
    {reset_i, vld, lsb, dpc, sgn, tw, ta, ts, ev, irq} = 10'h200;
    {xt, xr, uwe, uv, hr, rs, ar, anp} = 8'h00;
    {nreg, opa, opb, waits, drain} = '0;
    {num_errors, n_checks, ticks} = '0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({hm, pv, rdy, busy}, 4'h6);
    t_ops();
    t_refill();
    div(32'h00000010, 32'h3, 1'b0, 8'h04, 32'h5);
    div(32'h0, 32'h7, 1'b0, 8'h02, 32'h0);
    div(32'h1234, 32'h0, 1'b0, 8'h02, 32'h0);
    div(32'hffffffff, 32'h1, 1'b0, 8'h00, 32'hffffffff);
    div(32'hffffff9c, 32'h7, 1'b1, 8'h00, 32'hfffffff2);
    t_hint(cmt_pkg::OP_WAIT_EVENT_HINT);
    t_hint(cmt_pkg::OP_WAIT_INTERRUPT_HINT);
    t_mode();
    t_debug();
    refuse(1'b1, cmt_pkg::FORM_REG, cmt_pkg::OP_ALU);
    refuse(1'b0, cmt_pkg::FORM_IMM, cmt_pkg::OP_REG_LIST);
    stop_test();
  end
endmodule
